/* ptc_top.sv */
// timer and counter engine of a programmable controller
// assumes the scan sequencer and register master share clk
//
// Notes on behaviour
// (RULE1) slow timers advance per 100 ms, fast timers per 1 ms enabled.
// (RULE2) timer slots 1920 to 2047 belong to subroutines only.
// (RULE3) sequencer keeps timer values and presets within 0 to 32767.
// (RULE4) with several presets, the first one the value reaches rules.
// (RULE5) accumulating timer keeps its value while off, resumes from it.
// (RULE6) timer driven from several places is off if any condition off.
// (RULE7) subroutine plus accumulating use: off if any condition is off.
// (RULE8) timer dropping on to off with condition on restarts from zero.
// (RULE9) condition on energises coil and counts; at preset contact on.
// (RULE10) narrow counter adds one per rising input; at preset contact on.
// (RULE11) narrow counter at preset ignores pulses until cleared.
// (RULE12) wide counters exist only in slots 0 to 63.
// (RULE13) each wide counter has its own direction relay.
// (RULE14) unexecuted wide counter holds value; only clear zeroes it.
// (RULE15) relay off counts up, past preset too, contact stays on.
// (RULE16) relay on counts down; reaching preset turns contact off.
// (RULE17) wide counter value and preset are both 32 bits.
// (RULE18) clear zeroes value and turns coil and contact off.
// (RULE19) non-accumulating timer with condition off is zero and off.
// (RULE20) time bases come from a prescaler shared per timer type.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module ptc_top #(
	parameter int FAST_CYCLES = ptc_pkg::FAST_TICK_CYCLES
) (
	input wire logic clk, // 25 MHz system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic op_valid, // one operation this cycle
	input wire ptc_pkg::ptc_op_e op_kind, // operation kind
	input wire logic [10:0] op_slot, // timer or counter slot
	input wire logic op_cond, // condition contact of the operation
	input wire logic op_accum, // slow timer is accumulating
	input wire logic op_sub, // issued from a subroutine
	input wire logic [31:0] op_preset, // preset operand
	output logic res_valid, // result of last operation
	output logic [31:0] res_value, // value after the operation
	output logic res_no, // normally-open contact
	output logic res_nc, // normally-closed contact
	output logic res_coil, // coil state
	output logic res_err, // operation refused
	output logic ready, // reset sweep finished
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [31:0] reg_rdata // read data, cycle after reg_rd
);

	////////////////////////////////////////////////////////////////
	// time bases

	logic fast_tick;
	logic slow_tick;
	logic [7:0] fast_epoch;
	logic [7:0] slow_epoch;

	ptc_tick #(.DIV(FAST_CYCLES)) u_fast_tick (
		.clk(clk),
		.srst(srst),
		.in_pulse(1'b1),
		.out_pulse(fast_tick)
	); // RULE20

	ptc_tick #(.DIV(ptc_pkg::SLOW_PER_FAST)) u_slow_tick (
		.clk(clk),
		.srst(srst),
		.in_pulse(fast_tick),
		.out_pulse(slow_tick)
	); // RULE20

	// timers see elapsed ticks as an epoch difference, so a timer
	// idle for more than 255 ticks of its type loses a whole multiple of 256 ticks
	always_ff @(posedge clk) begin
		if (srst) begin
			fast_epoch <= '0;
			slow_epoch <= '0;
		end else begin
			fast_epoch <= fast_epoch + 8'(fast_tick); // RULE1
			slow_epoch <= slow_epoch + 8'(slow_tick); // RULE1
		end
	end

	////////////////////////////////////////////////////////////////
	// reset sweep of the slot stores

	logic init_busy;
	logic [10:0] init_idx;

	always_ff @(posedge clk) begin
		if (srst) begin
			init_busy <= 1'b1;
			init_idx <= '0;
			ready <= 1'b0;
		end else if (init_busy) begin
			init_idx <= init_idx + 11'h1;
			if (init_idx == ptc_pkg::SUB_LAST) begin
				init_busy <= 1'b0;
				ready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// slot stores

	logic [15:0] tval [ptc_pkg::SLOTS];
	logic tdone [ptc_pkg::SLOTS];
	logic tslow [ptc_pkg::SLOTS];
	logic [7:0] tstamp [ptc_pkg::SLOTS];
	logic tfresh [ptc_pkg::SLOTS];
	logic [15:0] cval [ptc_pkg::SLOTS];
	logic cdone [ptc_pkg::SLOTS];
	logic clast [ptc_pkg::SLOTS];

	logic go;
	logic is_timer;
	logic is_narrow;
	logic t_write;
	logic c_write;
	logic [10:0] wslot;

	assign go = op_valid && !init_busy;
	assign is_timer = op_kind == ptc_pkg::OP_SLOW_TIMER ||
		op_kind == ptc_pkg::OP_FAST_TIMER ||
		op_kind == ptc_pkg::OP_CLEAR_TIMER;
	assign is_narrow = op_kind == ptc_pkg::OP_NARROW_COUNT ||
		op_kind == ptc_pkg::OP_CLEAR_NARROW;
	assign wslot = init_busy ? init_idx : op_slot;

	////////////////////////////////////////////////////////////////
	// timer evaluation

	logic t_slow;
	logic t_accum;
	logic t_reserved;
	logic [15:0] t_pre;
	logic [15:0] t_cur;
	logic [7:0] t_now;
	logic [7:0] t_elapsed;
	logic [16:0] t_sum;
	logic [15:0] next_tval;
	logic next_tdone;
	logic next_tcoil;
	logic t_err;

	always_comb begin
		t_slow = op_kind == ptc_pkg::OP_SLOW_TIMER;
		t_accum = op_accum && t_slow;
		t_reserved = op_slot >= ptc_pkg::SUB_FIRST;
		t_pre = (op_preset[31:15] != 17'h0) ? ptc_pkg::TVAL_MAX :
			op_preset[15:0];
		t_cur = tval[op_slot];
		t_now = t_slow ? slow_epoch : fast_epoch;
		// time base change, sweep or clear restarts the tick count, so
		// time spent idle before the first execution is never counted
		t_elapsed = (tslow[op_slot] == t_slow && !tfresh[op_slot]) ?
			t_now - tstamp[op_slot] : 8'h0; // RULE1
		t_sum = {1'b0, t_cur} + {9'h0, t_elapsed};
		next_tval = t_cur;
		next_tdone = tdone[op_slot];
		next_tcoil = 1'b0;
		t_err = 1'b0;
		if (op_kind == ptc_pkg::OP_CLEAR_TIMER) begin
			next_tval = 16'h0; // RULE18
			next_tdone = 1'b0; // RULE8
		end else if (t_reserved && !op_sub) begin
			t_err = 1'b1; // RULE2
		end else if (!op_cond) begin
			next_tdone = 1'b0; // RULE6 RULE7
			if (!t_accum) begin
				next_tval = 16'h0; // RULE19
			end // RULE5
		end else begin
			next_tcoil = 1'b1; // RULE9
			if (t_cur >= t_pre) begin
				next_tdone = 1'b1; // RULE4
			end else if (t_sum >= {1'b0, t_pre}) begin
				next_tval = t_pre; // RULE9
				next_tdone = 1'b1; // RULE9
			end else begin
				next_tval = t_sum[15:0]; // RULE1 RULE5
			end
		end
	end

	assign t_write = init_busy || (go && is_timer && !t_err);

	always_ff @(posedge clk) begin
		if (t_write) begin
			tval[wslot] <= init_busy ? 16'h0 : next_tval;
			tdone[wslot] <= init_busy ? 1'b0 : next_tdone;
			tslow[wslot] <= init_busy ? 1'b0 : t_slow;
			tstamp[wslot] <= init_busy ? fast_epoch : t_now;
			tfresh[wslot] <= init_busy ||
				op_kind == ptc_pkg::OP_CLEAR_TIMER;
		end
	end

	////////////////////////////////////////////////////////////////
	// narrow counter evaluation

	logic [15:0] c_cur;
	logic [15:0] next_cval;
	logic next_cdone;

	always_comb begin
		c_cur = cval[op_slot];
		next_cval = c_cur;
		next_cdone = cdone[op_slot];
		if (op_kind == ptc_pkg::OP_CLEAR_NARROW) begin
			next_cval = 16'h0; // RULE18
			next_cdone = 1'b0; // RULE18
		end else if (cdone[op_slot]) begin
			next_cval = c_cur; // RULE11
		end else if (op_cond && !clast[op_slot]) begin
			next_cval = c_cur + 16'h1; // RULE10
			next_cdone = next_cval >= op_preset[15:0]; // RULE10
		end
	end

	assign c_write = init_busy || (go && is_narrow);

	always_ff @(posedge clk) begin
		if (c_write) begin
			cval[wslot] <= init_busy ? 16'h0 : next_cval;
			cdone[wslot] <= init_busy ? 1'b0 : next_cdone;
			clast[wslot] <= (init_busy ||
				op_kind == ptc_pkg::OP_CLEAR_NARROW) ? 1'b0 : op_cond;
		end
	end

	////////////////////////////////////////////////////////////////
	// wide counters

	logic [63:0] dir_bits;
	logic [12:0] view_sel;
	logic is_wide;
	logic w_err;
	logic [31:0] next_wval;
	logic next_wdone;
	logic [31:0] view_wval;
	logic view_wdone;

	assign is_wide = op_kind == ptc_pkg::OP_WIDE_COUNT ||
		op_kind == ptc_pkg::OP_CLEAR_WIDE;
	assign w_err = op_slot[10:6] != 5'h0; // RULE12

	ptc_wide u_wide (
		.clk(clk),
		.wr(init_busy || (go && is_wide && !w_err)), // RULE12
		.clr(init_busy || op_kind == ptc_pkg::OP_CLEAR_WIDE),
		.cond(op_cond),
		.dir(dir_bits[op_slot[5:0]]), // RULE13
		.slot(wslot[5:0]),
		.preset(op_preset), // RULE17
		.view_slot(view_sel[5:0]),
		.next_value(next_wval),
		.next_done(next_wdone),
		.view_value(view_wval),
		.view_done(view_wdone)
	);

	////////////////////////////////////////////////////////////////
	// result of each operation

	always_ff @(posedge clk) begin
		if (srst) begin
			res_valid <= 1'b0;
			res_value <= 32'h0;
			res_no <= 1'b0;
			res_nc <= 1'b1;
			res_coil <= 1'b0;
			res_err <= 1'b0;
		end else begin
			res_valid <= go;
			if (go) begin
				res_err <= 1'b0;
				res_coil <= 1'b0;
				if (is_timer) begin
					res_value <= {16'h0, next_tval};
					res_no <= next_tdone && !t_err;
					res_nc <= !(next_tdone && !t_err);
					res_coil <= next_tcoil && !t_err;
					res_err <= t_err;
				end else if (is_narrow) begin
					res_value <= {16'h0, next_cval};
					res_no <= next_cdone;
					res_nc <= !next_cdone;
					res_coil <= op_kind == ptc_pkg::OP_NARROW_COUNT;
				end else if (is_wide && !w_err) begin
					res_value <= next_wval;
					res_no <= next_wdone;
					res_nc <= !next_wdone;
					res_coil <= op_kind == ptc_pkg::OP_WIDE_COUNT;
				end else begin
					// plain bit clear or bad wide slot: value, contact and coil off, error only for the bad wide slot
					res_value <= 32'h0; // RULE18
					res_no <= 1'b0;
					res_nc <= 1'b1;
					res_err <= is_wide;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// register port

	always_ff @(posedge clk) begin
		if (srst) begin
			dir_bits <= {ptc_pkg::DIR_RST, ptc_pkg::DIR_RST};
			view_sel <= ptc_pkg::VIEW_RST;
		end else if (reg_wr) begin
			if (reg_addr == ptc_pkg::REG_DIR_LO) begin
				dir_bits[31:0] <= reg_wdata; // RULE13
			end
			if (reg_addr == ptc_pkg::REG_DIR_HI) begin
				dir_bits[63:32] <= reg_wdata; // RULE13
			end
			if (reg_addr == ptc_pkg::REG_VIEW_SEL) begin
				view_sel <= reg_wdata[12:0];
			end
		end
	end

	logic [31:0] view_data;
	logic [10:0] vslot;

	always_comb begin
		vslot = view_sel[ptc_pkg::VIEW_CLASS_LSB-1:ptc_pkg::VIEW_SLOT_LSB];
		view_data = 32'h0;
		unique case (view_sel[12:ptc_pkg::VIEW_CLASS_LSB])
			ptc_pkg::VIEW_TIMER: begin
				view_data[15:0] = tval[vslot];
				view_data[ptc_pkg::VIEW_DONE_BIT] = tdone[vslot];
			end
			ptc_pkg::VIEW_NARROW: begin
				view_data[15:0] = cval[vslot];
				view_data[ptc_pkg::VIEW_DONE_BIT] = cdone[vslot];
			end
			// the contact bit overlays the value's top bit here
			ptc_pkg::VIEW_WIDE: begin
				view_data = view_wval;
				view_data[ptc_pkg::VIEW_DONE_BIT] = view_wdone;
			end
			default: view_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst || !reg_rd) begin
			reg_rdata <= 32'h0;
		end else begin
			unique case (reg_addr)
				ptc_pkg::REG_DIR_LO: reg_rdata <= dir_bits[31:0];
				ptc_pkg::REG_DIR_HI: reg_rdata <= dir_bits[63:32];
				ptc_pkg::REG_EPOCH: reg_rdata <= {16'h0, slow_epoch,
					fast_epoch};
				ptc_pkg::REG_VIEW_SEL: reg_rdata <= {19'h0, view_sel};
				ptc_pkg::REG_VIEW_DATA: reg_rdata <= view_data;
				default: reg_rdata <= 32'h0;
			endcase
		end
	end

endmodule : ptc_top

/* ptc_pkg.sv */
// constants and types shared by the timer/counter engine
// assumes a 25 MHz system clock and a same-clock scan sequencer
package ptc_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int FAST_UNIT_NS = 1000000;
	localparam int SLOW_UNIT_NS = 100000000;
	localparam int FAST_TICK_CYCLES = FAST_UNIT_NS / CLK_PERIOD_NS;
	localparam int SLOW_PER_FAST = SLOW_UNIT_NS / FAST_UNIT_NS;

	localparam int SLOTS = 2048;
	localparam int SLOT_W = 11;
	localparam int WIDE_SLOTS = 64;
	localparam int WIDE_W = 6;
	localparam int EPOCH_W = 8;
	localparam logic [10:0] SUB_FIRST = 11'h780;
	localparam logic [10:0] SUB_LAST = 11'h7ff;
	localparam logic [15:0] TVAL_MAX = 16'h7fff;

	localparam logic [7:0] REG_DIR_LO = 8'h00;
	localparam logic [7:0] REG_DIR_HI = 8'h04;
	localparam logic [7:0] REG_EPOCH = 8'h08;
	localparam logic [7:0] REG_VIEW_SEL = 8'h0c;
	localparam logic [7:0] REG_VIEW_DATA = 8'h10;
	localparam int VIEW_SLOT_LSB = 0;
	localparam int VIEW_CLASS_LSB = 11;
	localparam int VIEW_DONE_BIT = 31;
	localparam int EPOCH_SLOW_LSB = 8;
	localparam logic [31:0] DIR_RST = 32'h0;
	localparam logic [12:0] VIEW_RST = 13'h0;
	localparam logic [1:0] VIEW_TIMER = 2'h0;
	localparam logic [1:0] VIEW_NARROW = 2'h1;
	localparam logic [1:0] VIEW_WIDE = 2'h2;

	typedef enum logic [2:0] {
		OP_SLOW_TIMER,
		OP_FAST_TIMER,
		OP_NARROW_COUNT,
		OP_WIDE_COUNT,
		OP_CLEAR_TIMER,
		OP_CLEAR_NARROW,
		OP_CLEAR_WIDE,
		OP_CLEAR_BIT
	} ptc_op_e;

endpackage : ptc_pkg

/* ptc_tick.sv */
// divider that emits one pulse for every DIV input pulses
// assumes in_pulse comes from logic on the same clock
`timescale 1ns/1ps
module ptc_tick #(
	parameter int DIV = 100
) (
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic in_pulse, // pulse to be counted
	output logic out_pulse // one pulse per DIV inputs
);

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] count;

	always_ff @(posedge clk) begin
		if (srst) begin
			count <= '0;
			out_pulse <= 1'b0;
		end else begin
			out_pulse <= in_pulse && (count == LAST);
			if (in_pulse) begin
				count <= (count == LAST) ? '0 : count + CW'(1);
			end
		end
	end

endmodule : ptc_tick

/* ptc_wide.sv */
// store and update logic of the 32-bit up/down counters
// assumes the caller registers the results and sweeps clr at reset
`timescale 1ns/1ps
module ptc_wide (
	input wire logic clk, // system clock
	input wire logic wr, // execute count or clear on slot
	input wire logic clr, // clear instead of count
	input wire logic cond, // condition input of the count
	input wire logic dir, // direction relay, high counts down
	input wire logic [5:0] slot, // wide counter slot
	input wire logic [31:0] preset, // double-word preset
	input wire logic [5:0] view_slot, // slot shown to software
	output logic [31:0] next_value, // value after this operation
	output logic next_done, // contact after this operation
	output logic [31:0] view_value, // value of view_slot
	output logic view_done // contact of view_slot
);

	logic [31:0] wval [ptc_pkg::WIDE_SLOTS];
	logic wdone [ptc_pkg::WIDE_SLOTS];
	logic wlast [ptc_pkg::WIDE_SLOTS];
	logic rise;

	assign view_value = wval[view_slot];
	assign view_done = wdone[view_slot];

	always_comb begin
		rise = cond && !wlast[slot];
		next_value = wval[slot];
		next_done = wdone[slot];
		if (clr) begin
			next_value = 32'h0; // RULE18
			next_done = 1'b0;
		end else if (rise && !dir) begin
			next_value = wval[slot] + 32'h1; // RULE15
			if (next_value == preset) begin
				next_done = 1'b1; // RULE15
			end
		end else if (rise) begin
			next_value = wval[slot] - 32'h1; // RULE16
			if (next_value == preset) begin
				next_done = 1'b0; // RULE16
			end
		end
	end

	// slots not executed keep value and contact untouched
	always_ff @(posedge clk) begin
		if (wr) begin // RULE14
			wval[slot] <= next_value; // RULE17
			wdone[slot] <= next_done;
			wlast[slot] <= clr ? 1'b0 : cond;
		end
	end

endmodule : ptc_wide

/* ptc_monitor.sv */
// port checker for the timer/counter engine
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module ptc_monitor (
	input wire logic clk, // system clock
	input wire logic srst, // reset
	input wire ptc_pkg::ptc_op_e op_kind, // kind
	input wire logic [10:0] op_slot, // slot
	input wire logic op_cond, // condition
	input wire logic op_sub, // subroutine
	input wire logic res_valid, // result strobe
	input wire logic [31:0] res_value, // value
	input wire logic res_no, // open contact
	input wire logic res_nc, // closed contact
	input wire logic res_coil, // coil
	input wire logic res_err // refused
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
////////////////////////////////////////////////////////////////////////
	a_contacts_opposite: assert property (res_nc == !res_no)
		else $error("contacts not opposite");
	a_timer_coil_on: assert property (res_valid &&
		$past(op_kind == ptc_pkg::OP_FAST_TIMER && op_cond &&
		op_slot < ptc_pkg::SUB_FIRST) |-> res_coil)
		else $error("timer coil off with condition on");
	a_reserved_refused: assert property (res_valid &&
		$past(op_kind inside {ptc_pkg::OP_SLOW_TIMER,
		ptc_pkg::OP_FAST_TIMER} && op_slot >= ptc_pkg::SUB_FIRST &&
		!op_sub) |-> res_err && !res_no)
		else $error("reserved slot used outside subroutine");
	a_wide_range: assert property (res_valid &&
		$past(op_kind == ptc_pkg::OP_WIDE_COUNT && op_slot > 11'h03f)
		|-> res_err)
		else $error("wide slot above 63 accepted");
	a_clear_zeroes: assert property (res_valid &&
		$past(op_kind inside {ptc_pkg::OP_CLEAR_TIMER,
		ptc_pkg::OP_CLEAR_NARROW, ptc_pkg::OP_CLEAR_WIDE})
		|-> res_value == 32'h0 && !res_no && !res_coil)
		else $error("clear left value or contact");
	a_timer_off_zero: assert property (res_valid &&
		$past(op_kind == ptc_pkg::OP_FAST_TIMER && !op_cond &&
		op_slot < ptc_pkg::SUB_FIRST) |-> res_value == 32'h0 && !res_no)
		else $error("idle timer not cleared");
	a_timer_range: assert property (res_valid &&
		$past(op_kind inside {ptc_pkg::OP_SLOW_TIMER,
		ptc_pkg::OP_FAST_TIMER}) |-> res_value <= 32'h00007fff)
		else $error("timer value out of range");
	a_value_holds: assert property (!res_valid |->
		$stable(res_value) && $stable(res_no))
		else $error("result changed without operation");
endmodule : ptc_monitor

bind ptc_top ptc_monitor u_ptc_monitor (.clk(clk), .srst(srst),
	.op_kind(op_kind), .op_slot(op_slot), .op_cond(op_cond),
	.op_sub(op_sub), .res_valid(res_valid), .res_value(res_value),
	.res_no(res_no), .res_nc(res_nc), .res_coil(res_coil),
	.res_err(res_err));

/* ptc_seq_model.sv */
// scan sequencer model, one operation per call of issue
// assumes the engine registers its answer on the taking edge itself
`timescale 1ns/1ps
module ptc_seq_model (
	input wire logic clk, // system clock
	input wire logic res_valid, // result strobe
	output logic op_valid, // request
	output ptc_pkg::ptc_op_e op_kind, // kind
	output logic [10:0] op_slot, // slot
	output logic op_cond, // condition
	output logic op_accum, // accumulating
	output logic op_sub, // subroutine
	output logic [31:0] op_preset, // preset
	output logic got // result strobe seen
);
	initial begin
		op_valid = 1'b0;
		op_kind = ptc_pkg::OP_CLEAR_BIT;
		{op_slot, op_cond, op_accum, op_sub, op_preset, got} = '0;
	end
	task issue(input ptc_pkg::ptc_op_e k, input logic [10:0] s,
		input logic c, a, u, input logic [31:0] p);
		@(posedge clk);
		op_valid <= 1'b1;
		op_kind <= k;
		op_slot <= s;
		op_cond <= c;
		op_accum <= a;
		op_sub <= u;
		// timer presets never leave the legal span
		op_preset <= (k < ptc_pkg::OP_NARROW_COUNT && p > 32'h7fff) ?
			32'h7fff : p;
		@(posedge clk);
		op_valid <= 1'b0;
		// idle slot, condition and preset flip so their stale values are never reused
		op_slot <= ~s;
		op_cond <= ~c;
		op_preset <= ~p;
		#1 got = res_valid;
	endtask : issue
endmodule : ptc_seq_model

/* tb.sv */
// self-checking bench for the timer/counter engine
// assumes the sequencer model drives the operation port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
	logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, res_value, rd, e0;
	logic op_valid, op_cond, op_accum, op_sub, res_valid, res_no;
	logic res_nc, res_coil, res_err, ready, got;
	logic [10:0] op_slot;
	logic [31:0] op_preset;
	ptc_pkg::ptc_op_e op_kind;
	int n_fail = 0, total_checks = 0, i;
	ptc_top #(.FAST_CYCLES(10)) u_ptc_top (.clk(clk), .srst(srst),
		.op_valid(op_valid), .op_kind(op_kind), .op_slot(op_slot),
		.op_cond(op_cond), .op_accum(op_accum), .op_sub(op_sub),
		.op_preset(op_preset), .res_valid(res_valid),
		.res_value(res_value), .res_no(res_no), .res_nc(res_nc),
		.res_coil(res_coil), .res_err(res_err), .ready(ready),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	ptc_seq_model u_ptc_seq_model (.clk(clk), .res_valid(res_valid),
		.op_valid(op_valid), .op_kind(op_kind), .op_slot(op_slot),
		.op_cond(op_cond), .op_accum(op_accum), .op_sub(op_sub),
		.op_preset(op_preset), .got(got));
	always #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////
	task stop_test;
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	// n is the spacing in cycles between two taking edges
	task gap(input int n);
		repeat (n - 2) @(posedge clk);
	endtask : gap
	task run(input ptc_pkg::ptc_op_e k, input logic [10:0] s,
		input logic c, a, u, input logic [31:0] p, ev,
		input logic eno, ee);
		logic ec;
		// coil follows the condition for timers, on for count operations
		ec = k == ptc_pkg::OP_NARROW_COUNT || k == ptc_pkg::OP_WIDE_COUNT ||
			(k < ptc_pkg::OP_NARROW_COUNT && c);
		u_ptc_seq_model.issue(k, s, c, a, u, p);
		`CHK("res_valid", 1'b1, got)
		`CHK("res_err", ee, res_err)
		if (!ee) begin
			`CHK("res_value", ev, res_value)
			`CHK("res_no", eno, res_no)
			`CHK("res_nc", !eno, res_nc)
			`CHK("res_coil", ec, res_coil)
		end
	endtask : run
////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 3000 && ready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK("ready", 1'b1, ready)
		reg_read(8'h14, rd);
		`CHK("unmapped", 32'h0, rd)
		reg_read(8'h08, e0);
		gap(100);
		reg_read(8'h08, rd);
		`CHK("fast_epoch", 8'h0a, 8'(rd[7:0] - e0[7:0]))
		run(ptc_pkg::OP_FAST_TIMER, 3, 1, 0, 0, 7, 0, 0, 0);
		gap(50);
		run(ptc_pkg::OP_FAST_TIMER, 3, 1, 0, 0, 7, 5, 0, 0);
		gap(50);
		run(ptc_pkg::OP_FAST_TIMER, 3, 1, 0, 0, 7, 7, 1, 0);
		run(ptc_pkg::OP_CLEAR_TIMER, 3, 1, 0, 0, 7, 0, 0, 0);
		run(ptc_pkg::OP_FAST_TIMER, 3, 0, 0, 0, 7, 0, 0, 0);
		run(ptc_pkg::OP_SLOW_TIMER, 5, 1, 1, 0, 3, 0, 0, 0);
		gap(1000);
		run(ptc_pkg::OP_SLOW_TIMER, 5, 1, 1, 0, 3, 1, 0, 0);
		run(ptc_pkg::OP_SLOW_TIMER, 5, 0, 1, 0, 3, 1, 0, 0);
		run(ptc_pkg::OP_SLOW_TIMER, 11'h780, 1, 0, 0, 3, 0, 0, 1);
		run(ptc_pkg::OP_SLOW_TIMER, 11'h7ff, 1, 0, 1, 3, 0, 0, 0);
		run(ptc_pkg::OP_SLOW_TIMER, 11'h7ff, 0, 1, 1, 3, 0, 0, 0);
		for (i = 1; i <= 5; i++) begin
			run(ptc_pkg::OP_NARROW_COUNT, 9, 0, 0, 0, 3,
				32'(i > 3 ? 3 : i - 1), i > 3, 0);
			run(ptc_pkg::OP_NARROW_COUNT, 9, 1, 0, 0, 3,
				32'(i > 3 ? 3 : i), i > 2, 0);
		end
		reg_write(8'h0c, 32'h809);
		reg_read(8'h0c, rd);
		`CHK("view_sel", 32'h809, rd)
		reg_read(8'h10, rd);
		`CHK("view_narrow", 32'h80000003, rd)
		run(ptc_pkg::OP_CLEAR_NARROW, 9, 1, 0, 0, 3, 0, 0, 0);
		for (i = 1; i <= 4; i++) begin
			run(ptc_pkg::OP_WIDE_COUNT, 2, 0, 0, 0, 2,
				32'(i - 1), i > 2, 0);
			run(ptc_pkg::OP_WIDE_COUNT, 2, 1, 0, 0, 2,
				32'(i), i > 1, 0);
		end
		reg_write(8'h00, 32'h4);
		reg_read(8'h00, rd);
		`CHK("relays", 32'h4, rd)
		for (i = 1; i <= 3; i++) begin
			run(ptc_pkg::OP_WIDE_COUNT, 2, 0, 0, 0, 2,
				32'(5 - i), i < 3, 0);
			run(ptc_pkg::OP_WIDE_COUNT, 2, 1, 0, 0, 2,
				32'(4 - i), i < 2, 0);
		end
		gap(200);
		run(ptc_pkg::OP_WIDE_COUNT, 2, 0, 0, 0, 2, 1, 0, 0);
		run(ptc_pkg::OP_WIDE_COUNT, 11'h040, 1, 0, 0, 2, 0, 0, 1);
		run(ptc_pkg::OP_CLEAR_WIDE, 2, 0, 0, 0, 2, 0, 0, 0);
		run(ptc_pkg::OP_WIDE_COUNT, 2, 1, 0, 0, 32'hffffffff,
			32'hffffffff, 0, 0);
		run(ptc_pkg::OP_CLEAR_BIT, 4, 1, 0, 0, 0, 0, 0, 0);
		stop_test;
	end
endmodule : tb
